// [include/prs_consts.svh]
// offsets, field positions, reset values and timing counts of the resampler
// assumes inclusion by bare name from the design files and the bench
//
// Function
// - filter length is multiplies times interpolation, max 512
// - multiplies per output come from register 17
// - symmetry disable picks symmetric or non-symmetric filter
// - 256 words of 12-bit coefficients, one/two/four blocks
// - each channel selects its own coefficient block
// - non-symmetric mode halves maximum length per block
// - lowest address coefficient meets newest sample
// - several coefficient sets interleave word by word
// - interpolation factor is derived power of two
// - two multiplies per clock bound the multiplies
// - compute clock divisor from one to 256
// - up-shift 0..15 then round to 12..24 bits
// - gain is coefficient sum over 32768 times factor
// - four stored rate words chosen by map register
// - map changes apply at selected sync instant
// - 32-bit rate word, 2^26 per input sample
// - 64-word delay line split by channel count
// - fractional steps use nearest interpolated phase
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

// register word indices, byte address is four times these
`define PRS_IDX_LAYOUT    6'h10
`define PRS_IDX_MULT      6'h11
`define PRS_IDX_FSEL      6'h12
`define PRS_IDX_SHRND     6'h13
`define PRS_IDX_RSYNC     6'h15
`define PRS_IDX_DIV       6'h16
`define PRS_IDX_MAP       6'h17
`define PRS_IDX_COEF_ADDR 6'h20
`define PRS_IDX_COEF_DATA 6'h21
`define PRS_IDX_STATUS    6'h24
`define PRS_IDX_RATE0     6'h30

// reset values
`define PRS_RST_LAYOUT 8'h00
`define PRS_RST_MULT   8'h0f
`define PRS_RST_SHRND  8'h30
`define PRS_RST_RATE   32'h04000000

// rate sync sources
`define PRS_SYNC_NOW   2'h0
`define PRS_SYNC_PIN   2'h1
`define PRS_SYNC_OUT   2'h2

// timing and scaling
`define PRS_UNIT       34'sh004000000
`define PRS_HALF_PH    34'sh002000000
`define PRS_PH_LSB     26
`define PRS_NORM_SHIFT 15
`define PRS_RND_BASE   12
`define PRS_MAX_LEN    13'd512

`endif

// [include/prs_pkg.sv]
// types shared by the resampler modules
// assumes nothing of its surroundings
package prs_pkg;
  // gray coded engine states along idle, calc, done
  typedef enum logic [1:0] {
    PRS_IDLE = 2'b00,
    PRS_CALC = 2'b01,
    PRS_DONE = 2'b11
  } prs_state_t;
endpackage

// [include/prs_res_if.sv]
// carrier between mac engine and final shift/round stage
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface prs_res_if #(
  parameter int ACC_W  = 44,
  parameter int DATA_W = 24
);
  logic                     valid;
  logic [1:0]               chan;
  logic signed [ACC_W-1:0]  acc;
  logic [3:0]               shift;
  logic [1:0]               rnd;
  logic                     out_valid;
  logic [1:0]               out_chan;
  logic [DATA_W-1:0]        out_data;
  modport src (output valid, chan, acc, shift, rnd, input out_valid, out_chan, out_data);
  modport dst (input valid, chan, acc, shift, rnd, output out_valid, out_chan, out_data);
endinterface
`default_nettype wire

// [verilog/prs_shift_round.sv]
// final up-shift, round and saturate of one mac result
// assumes acc holds sum of data times coefficient, one result per valid
`timescale 1ns/1ps
`default_nettype none
`include "prs_consts.svh"
module prs_shift_round #(
  parameter int ACC_W  = 44,
  parameter int DATA_W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  prs_res_if.dst   rif
);
  localparam int W = ACC_W + 16;
  logic signed [W-1:0] sc;
  logic signed [W-1:0] rd;
  logic signed [W-1:0] lim;
  logic signed [W-1:0] q;
  logic [4:0]          keep;
  logic [5:0]          r;
  logic                valid_ff;
  logic [1:0]          chan_ff;
  logic [DATA_W-1:0]   data_ff;

  // shift, round half up, clamp to kept width
  always_comb begin
    keep = 5'(`PRS_RND_BASE + 4 * rif.rnd);
    r    = 6'(`PRS_NORM_SHIFT + DATA_W) - 6'(keep);
    sc   = W'(rif.acc) <<< rif.shift;
    rd   = (sc + (W'(1) <<< (r - 6'd1))) >>> r;
    lim  = (W'(1) <<< (keep - 5'd1)) - W'(1);
    q    = (rd > lim) ? lim : ((rd < -lim - W'(1)) ? -lim - W'(1) : rd);
  end

  // registered result, unused lsbs cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= 1'b0;
      chan_ff  <= 2'h0;
      data_ff  <= '0;
    end else begin
      valid_ff <= rif.valid;
      if (rif.valid) begin
        chan_ff <= rif.chan;
        data_ff <= DATA_W'(q <<< (DATA_W - 32'(keep)));
      end
    end
  end
  assign rif.out_valid = valid_ff;
  assign rif.out_chan  = chan_ff;
  assign rif.out_data  = data_ff;

  round_lsb_a: assert property (@(posedge clk) disable iff (!rst_n)
    rif.valid && rif.rnd == 2'h0 |=> data_ff[11:0] == 12'h000)
    else $error("lsbs below 12-bit rounding not cleared");
endmodule
`default_nettype wire

// [verilog/prs_resampler.sv]
// polyphase resampler: apb registers, delay line, coefficient memory,
// mac engine and rate map; results go through prs_shift_round
// assumes in_* from same-clock logic, out_* into a fifo that never stalls
`timescale 1ns/1ps
`default_nettype none
`include "prs_consts.svh"
module prs_resampler
  import prs_pkg::*;
#(
  parameter int DATA_W   = 24,
  parameter int COEF_W   = 12,
  parameter int CM_DEPTH = 256,
  parameter int DL_DEPTH = 64
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sync_in,
  input  wire logic              in_valid,
  input  wire logic [1:0]        in_chan,
  input  wire logic [DATA_W-1:0] in_data,
  output logic                   in_ready,
  output logic                   out_valid,
  output logic [1:0]             out_chan,
  output logic [DATA_W-1:0]      out_data
);
  localparam int ACC_W = DATA_W + COEF_W + 8;

  if (CM_DEPTH != 256 || DL_DEPTH != 64 || COEF_W > 16)
    $error("prs_resampler: unsupported memory geometry");

  logic [1:0]               rst_sync_ff;
  logic                     rst_i_n;
  logic                     sync_meta_ff;
  logic                     sync_ff;
  logic                     sync_prev_ff;
  logic                     sync_rise;
  logic [5:0]               idx;
  logic                     hit;
  logic                     reg_wr;
  logic [31:0]              rd_val;
  logic [31:0]              prdata_ff;
  logic                     pready_ff;
  logic                     pslverr_ff;
  logic [7:0]               layout_ff;
  logic [7:0]               mult_ff;
  logic [7:0]               fsel_ff;
  logic [7:0]               shrnd_ff;
  logic [7:0]               rsync_ff;
  logic [7:0]               div_ff;
  logic [7:0]               map_ff;
  logic [7:0]               map_act_ff;
  logic [7:0]               coef_addr_ff;
  logic [31:0]              rate_ff [4];
  logic signed [COEF_W-1:0] cmem [CM_DEPTH];
  logic signed [DATA_W-1:0] dline [DL_DEPTH];
  logic [1:0]               nf_lg;
  logic [1:0]               ch_lg;
  logic [6:0]               multiplies_per_output;
  logic                     sym_dis;
  logic [2:0]               lg_nd;
  logic [6:0]               nd;
  logic [12:0]              flen;
  logic                     len_over;
  logic [7:0]               div_cnt_ff;
  logic                     tick;
  prs_state_t               st_ff;
  prs_state_t               st_nxt;
  logic                     in_ready_ff;
  logic                     accept;
  logic [1:0]               ch_in;
  logic [1:0]               cur_ff;
  logic [6:0]               k_ff;
  logic                     last;
  logic signed [ACC_W-1:0]  acc_ff;
  logic                     emit_ff;
  logic signed [33:0]       ph_ff [4];
  logic [5:0]               wp_ff [4];
  logic signed [33:0]       ph_in_new;
  logic signed [33:0]       ph_after;
  logic [33:0]              mraw;
  logic [6:0]               m_cur;
  logic [5:0]               seg_mask;
  logic [1:0]               fsel_cur;
  logic [7:0]               ca [2];
  logic [5:0]               da [2];
  logic signed [ACC_W-1:0]  pr [2];
  logic [6:0]               calc_tk_ff;
  logic [12:0]              tap0;

  // interpolation factor as log2 of largest fitting power of two
  function automatic logic [2:0] interp_lg(input logic [6:0] nm, input logic [1:0] fl,
                                           input logic sd);
    logic [15:0] lim;
    logic [2:0]  r;
    lim = sd ? 16'd256 : 16'd512;
    r   = 3'd0;
    for (int i = 1; i < 7; i++) begin
      if (((16'(nm) << fl) << i) <= lim) r = 3'(i);
    end
    return r;
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync_ff <= 2'b00;
    else        rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_i_n = rst_sync_ff[1];

  // sync pin synchroniser and edge detect
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      sync_meta_ff <= 1'b0;
      sync_ff      <= 1'b0;
      sync_prev_ff <= 1'b0;
    end else begin
      sync_meta_ff <= sync_in;
      sync_ff      <= sync_meta_ff;
      sync_prev_ff <= sync_ff;
    end
  end
  assign sync_rise = sync_ff && !sync_prev_ff;

  // apb decode and read mux
  assign idx    = paddr[7:2];
  assign reg_wr = psel && penable && pready_ff && pwrite && hit;
  always_comb begin
    rd_val = 32'h0;
    hit    = 1'b1;
    case (idx)
      `PRS_IDX_LAYOUT:    rd_val = {24'h0, layout_ff};
      `PRS_IDX_MULT:      rd_val = {24'h0, mult_ff};
      `PRS_IDX_FSEL:      rd_val = {24'h0, fsel_ff};
      `PRS_IDX_SHRND:     rd_val = {24'h0, shrnd_ff};
      `PRS_IDX_RSYNC:     rd_val = {24'h0, rsync_ff};
      `PRS_IDX_DIV:       rd_val = {24'h0, div_ff};
      `PRS_IDX_MAP:       rd_val = {24'h0, map_ff};
      `PRS_IDX_COEF_ADDR: rd_val = {24'h0, coef_addr_ff};
      `PRS_IDX_COEF_DATA: rd_val = {{(32-COEF_W){1'b0}}, cmem[coef_addr_ff]};
      `PRS_IDX_STATUS:    rd_val = {st_ff != PRS_IDLE, len_over, 4'h0, flen[9:0], 9'h0, nd};
      default: begin
        if (idx[5:2] == 4'(`PRS_IDX_RATE0 >> 2)) rd_val = rate_ff[idx[1:0]];
        else hit = 1'b0;
      end
    endcase
  end

  // apb answer: data captured in setup, ready one cycle later
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !hit;
      if (psel && !penable) prdata_ff <= rd_val;
    end
  end
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // control registers
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      layout_ff    <= `PRS_RST_LAYOUT;
      mult_ff      <= `PRS_RST_MULT;
      fsel_ff      <= 8'h00;
      shrnd_ff     <= `PRS_RST_SHRND;
      rsync_ff     <= 8'h00;
      div_ff       <= 8'h00;
      map_ff       <= 8'h00;
      coef_addr_ff <= 8'h00;
      for (int i = 0; i < 4; i++) rate_ff[i] <= `PRS_RST_RATE;
    end else if (reg_wr) begin
      case (idx)
        `PRS_IDX_LAYOUT:    layout_ff    <= pwdata[7:0];
        `PRS_IDX_MULT:      mult_ff      <= pwdata[7:0];
        `PRS_IDX_FSEL:      fsel_ff      <= pwdata[7:0];
        `PRS_IDX_SHRND:     shrnd_ff     <= pwdata[7:0];
        `PRS_IDX_RSYNC:     rsync_ff     <= pwdata[7:0];
        `PRS_IDX_DIV:       div_ff       <= pwdata[7:0];
        `PRS_IDX_MAP:       map_ff       <= pwdata[7:0];
        `PRS_IDX_COEF_ADDR: coef_addr_ff <= pwdata[7:0];
        `PRS_IDX_COEF_DATA: coef_addr_ff <= coef_addr_ff + 8'h01;
        default: begin
          if (idx[5:2] == 4'(`PRS_IDX_RATE0 >> 2)) rate_ff[idx[1:0]] <= pwdata;
        end
      endcase
    end
  end

  // coefficient memory, written through the data window
  always_ff @(posedge clk) begin
    if (reg_wr && idx == `PRS_IDX_COEF_DATA)
      cmem[coef_addr_ff] <= pwdata[COEF_W-1:0];
  end

  // active rate map follows the chosen sync source
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) map_act_ff <= 8'h00;
    else if (rsync_ff[1:0] == `PRS_SYNC_NOW ||
             (rsync_ff[1:0] == `PRS_SYNC_PIN && sync_rise) ||
             (rsync_ff[1:0] == `PRS_SYNC_OUT && st_ff == PRS_DONE))
      map_act_ff <= map_ff;
  end

  // configuration decode
  assign nf_lg    = (layout_ff[1:0] > 2'd2) ? 2'd2 : layout_ff[1:0];
  assign ch_lg    = (layout_ff[5:4] > 2'd2) ? 2'd2 : layout_ff[5:4];
  assign multiplies_per_output    = mult_ff[6:0];
  assign sym_dis  = mult_ff[7];
  assign lg_nd    = interp_lg(multiplies_per_output, nf_lg, sym_dis);
  assign nd       = 7'(1 << lg_nd);
  assign flen     = 13'(multiplies_per_output) << lg_nd;
  assign len_over = flen > ((sym_dis ? `PRS_MAX_LEN >> 1 : `PRS_MAX_LEN) >> nf_lg);
  assign seg_mask = 6'h3f >> ch_lg;

  // compute divider, one tick every div+1 clocks
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n)  div_cnt_ff <= 8'h00;
    else if (tick) div_cnt_ff <= 8'h00;
    else           div_cnt_ff <= div_cnt_ff + 8'h01;
  end
  assign tick = div_cnt_ff >= div_ff;

  // channel, phase and nearest polyphase branch
  assign ch_in     = in_chan & 2'(2'b11 >> (2'd2 - ch_lg));
  assign accept    = in_valid && in_ready_ff && st_ff == PRS_IDLE;
  assign ph_in_new = ph_ff[ch_in] - `PRS_UNIT;
  assign ph_after  = ph_ff[cur_ff] + $signed({2'b00, rate_ff[map_act_ff[2*cur_ff +: 2]]});
  assign mraw      = ((34'(-ph_ff[cur_ff]) << lg_nd) + `PRS_HALF_PH) >> `PRS_PH_LSB;
  assign m_cur     = (mraw >= 34'(nd)) ? nd - 7'd1 : mraw[6:0];
  assign fsel_cur  = fsel_ff[2*cur_ff +: 2] & 2'(2'b11 >> (2'd2 - nf_lg));
  assign last      = k_ff + 7'd2 >= multiplies_per_output;

  // two taps per clock: coefficient and delay line addressing
  for (genvar j = 0; j < 2; j++) begin : g_lane
    logic [12:0] t;
    logic [12:0] h;
    logic [5:0]  dp;
    assign t     = 13'(m_cur) + ((13'(k_ff) + 13'(j)) << lg_nd);
    assign h     = (!sym_dis && t >= (flen >> 1)) ? flen - 13'd1 - t : t;
    assign ca[j] = 8'(h << nf_lg) | 8'(fsel_cur);
    assign dp    = 6'(wp_ff[cur_ff] - 6'd1 - 6'(k_ff) - 6'(j));
    assign da[j] = (6'(cur_ff) << (3'd6 - 3'(ch_lg))) | (dp & seg_mask);
    assign pr[j] = (k_ff + 7'(j) < multiplies_per_output) ? ACC_W'(dline[da[j]] * cmem[ca[j]]) : '0;
  end
  assign tap0 = g_lane[0].h;

  // engine state sequencing
  always_comb begin
    st_nxt = st_ff;
    case (st_ff)
      PRS_IDLE: if (accept && ph_in_new <= 0) st_nxt = PRS_CALC;
      PRS_CALC: if (tick && last) st_nxt = PRS_DONE;
      PRS_DONE: st_nxt = (ph_after <= 0) ? PRS_CALC : PRS_IDLE;
      default:  st_nxt = PRS_IDLE;
    endcase
  end

  // engine registers: state, tap counter, accumulator
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      st_ff       <= PRS_IDLE;
      in_ready_ff <= 1'b0;
      cur_ff      <= 2'h0;
      k_ff        <= 7'h00;
      acc_ff      <= '0;
      emit_ff     <= 1'b0;
    end else begin
      st_ff       <= st_nxt;
      in_ready_ff <= st_nxt == PRS_IDLE;
      emit_ff     <= st_ff == PRS_CALC && tick && last;
      if (accept) cur_ff <= ch_in;
      if (st_ff != PRS_CALC) begin
        k_ff   <= 7'h00;
        // idle and done both leave the sum cleared for the next output
        acc_ff <= '0;
      end else if (tick) begin
        k_ff   <= k_ff + 7'd2;
        acc_ff <= acc_ff + pr[0] + pr[1];
      end
    end
  end

  // per-channel phase and write pointer
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      for (int i = 0; i < 4; i++) begin
        ph_ff[i] <= '0;
        wp_ff[i] <= 6'h00;
      end
    end else if (accept) begin
      ph_ff[ch_in] <= ph_in_new;
      wp_ff[ch_in] <= (wp_ff[ch_in] + 6'd1) & seg_mask;
    end else if (st_ff == PRS_DONE) begin
      ph_ff[cur_ff] <= ph_after;
    end
  end

  // delay line write, newest sample at pointer
  always_ff @(posedge clk) begin
    if (accept)
      dline[(6'(ch_in) << (3'd6 - 3'(ch_lg))) | (wp_ff[ch_in] & seg_mask)] <= in_data;
  end

  // tick count inside one calculation, read by checks
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n)                calc_tk_ff <= 7'h00;
    else if (st_ff != PRS_CALC)  calc_tk_ff <= 7'h00;
    else if (tick)               calc_tk_ff <= calc_tk_ff + 7'h01;
  end

  // final shift and round stage
  prs_res_if #(.ACC_W(ACC_W), .DATA_W(DATA_W)) rif ();
  assign rif.valid = emit_ff;
  assign rif.chan  = cur_ff;
  assign rif.acc   = acc_ff;
  assign rif.shift = shrnd_ff[3:0];
  assign rif.rnd   = shrnd_ff[5:4];
  prs_shift_round #(.ACC_W(ACC_W), .DATA_W(DATA_W)) u_round (
    .clk   (clk),
    .rst_n (rst_i_n),
    .rif   (rif)
  );
  assign in_ready  = in_ready_ff;
  assign out_valid = rif.out_valid;
  assign out_chan  = rif.out_chan;
  assign out_data  = rif.out_data;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_i_n);

  apb_answer_a: assert property (psel && !penable |=> pready && penable ##1 !pready)
    else $error("apb answer not one cycle after setup");
  calc_ticks_a: assert property (st_ff == PRS_DONE && multiplies_per_output >= 7'd2 |->
    calc_tk_ff == 7'((multiplies_per_output + 7'd1) >> 1))
    else $error("mac did not take two taps per tick");
  interp_pow_a: assert property (st_ff == PRS_CALC |->
    ((16'(multiplies_per_output) << nf_lg) << lg_nd) <= (sym_dis ? 16'd256 : 16'd512) &&
    (lg_nd == 3'd6 || ((16'(multiplies_per_output) << nf_lg) << (lg_nd + 3'd1)) > (sym_dis ? 16'd256 : 16'd512)))
    else $error("interpolation factor not largest power of two");
  phase_near_a: assert property (st_ff == PRS_CALC |-> m_cur < nd)
    else $error("phase branch out of range");
  sym_half_a: assert property (st_ff == PRS_CALC && !sym_dis && flen <= `PRS_MAX_LEN |->
    tap0 < (flen >> 1) || tap0 >= flen)
    else $error("symmetric tap not folded into first half");
  filt_lane_a: assert property (st_ff == PRS_CALC && nf_lg == 2'd2 |->
    ca[0][1:0] == fsel_ff[2*cur_ff +: 2])
    else $error("coefficient sets not interleaved");
  map_sync_a: assert property (rsync_ff[1:0] == `PRS_SYNC_PIN && !sync_rise
    && $stable(rsync_ff) |=> $stable(map_act_ff))
    else $error("rate map changed without sync");
  emit_out_a: assert property (emit_ff |=> out_valid && out_chan == $past(cur_ff))
    else $error("result not delivered one cycle after mac end");
  ready_idle_a: assert property (in_ready |-> st_ff == PRS_IDLE ##1 st_ff != PRS_DONE)
    else $error("input accepted while engine busy");
endmodule
`default_nettype wire

// [test/prs_stream_model.sv]
// far side model: sample source ahead of the resampler, output sink after it
// assumes the bench calls send and reads got through the instance
`timescale 1ns/1ps
`default_nettype none
module prs_stream_model (
  input  wire logic        clk,
  input  wire logic        in_ready,
  input  wire logic        out_valid,
  input  wire logic [23:0] out_data,
  output logic             in_valid,
  output logic [23:0]      in_data
);
  logic [23:0] got[$];

  // offer one sample, hold it until taken, then show the inverse
  task send(input logic [23:0] v);
    @(posedge clk);
    in_valid <= 1'b1;
    in_data  <= v;
    do @(posedge clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    in_data  <= ~v;
  endtask

  // sink never stalls, records every output pulse
  always @(posedge clk) begin
    if (out_valid === 1'b1) got.push_back(out_data);
  end

  initial begin
    in_valid = 1'b0;
    in_data  = 24'h000000;
  end
endmodule
`default_nettype wire

// [test/prs_resampler_tb.sv]
// bench for prs_resampler: registers, status, bypass data and rate map
// assumes design files and prs_stream_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "prs_consts.svh"
module prs_resampler_tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, sync_in, e;
  logic        in_valid, in_ready, out_valid;
  logic [1:0]  out_chan;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, s;
  logic [23:0] in_data, out_data, d;
  logic [23:0] ex[$];
  logic [5:0]  ri[8];
  logic [31:0] rv[8];
  int          n_fail, num_checks, m, ns, nf, x, sh;

  prs_resampler uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sync_in(sync_in), .in_valid(in_valid), .in_chan(2'h0),
    .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
    .out_chan(out_chan), .out_data(out_data));
  prs_stream_model src (.clk(clk), .in_ready(in_ready), .out_valid(out_valid),
    .out_data(out_data), .in_valid(in_valid), .in_data(in_data));

  // free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // largest power of two not above p
  function automatic int fl2(input int p);
    int r;
    r = 1;
    while (r * 2 <= p) r = r * 2;
    return r;
  endfunction

  // bypass tap of 1024, up-shift, round half up to 12+4k msbs, saturate
  function automatic logic [23:0] exp_out(input logic [23:0] v, input int t, input int k);
    longint a, lim;
    int     dr;
    dr  = 27 - 4 * k;
    lim = 64'sh1 <<< (11 + 4 * k);
    a   = ((longint'($signed(v)) * 1024) <<< t) + (64'sh1 <<< (dr - 1));
    a   = a >>> dr;
    if (a >= lim) a = lim - 1;
    if (a < -lim) a = -lim;
    return 24'(a <<< (12 - 4 * k));
  endfunction

  task chk(input string nm, input logic [31:0] xp, input logic [31:0] g);
    num_checks++;
    if (g !== xp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, xp, g);
    end
  endtask

  // one apb transfer, answer taken at the edge where pready is high
  task apb(input logic w, input logic [5:0] i, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    if (pready !== 1'b1) n_fail++;  // no answer counts as a mismatch
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // send cnt samples, then check output count and, for k>=0, data
  task run(input int cnt, input int want, input int k, input int t);
    int n;
    src.got.delete();
    ex.delete();
    for (int i = 0; i < cnt; i++) begin
      d = rnd();
      src.send(d);
      if (k >= 0) ex.push_back(exp_out(d, t, k));
    end
    n = 0;
    while (src.got.size() < want && n < 300) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    chk("output count", 32'(want), 32'(src.got.size()));
    chk("output channel", 32'h0, {30'h0, out_chan});
    foreach (ex[i]) chk("output data", {8'h00, ex[i]}, {8'h00, src.got[i]});
  endtask

  task stop_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    s = 32'h0001666c;
    n_fail = 0;
    num_checks = 0;
    {rst_n, psel, penable, pwrite, sync_in} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ri = '{`PRS_IDX_LAYOUT, `PRS_IDX_MULT, `PRS_IDX_FSEL, `PRS_IDX_SHRND,
           `PRS_IDX_RSYNC, `PRS_IDX_DIV, `PRS_IDX_MAP, `PRS_IDX_RATE0};
    rv = '{`PRS_RST_LAYOUT, `PRS_RST_MULT, 0, `PRS_RST_SHRND, 0, 0, 0, `PRS_RST_RATE};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values of the register table
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ri[i], 0);
      chk("reset value", rv[i], q);
    end
    apb(1'b1, 6'h3f, 32'hffffffff);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'b0, 6'h3f, 0);
    chk("unmapped data", 32'h0, q);
    // per channel selections and divider read back
    foreach (ri[i]) if (i == 2 || i == 5 || i == 6) begin
      d = rnd();
      apb(1'b1, ri[i], {24'h0, d[7:0]});
      apb(1'b0, ri[i], 0);
      chk("readback", {24'h0, d[7:0]}, q);
      apb(1'b1, ri[i], 0);
    end
    // derived interpolation factor and length, legal multiplies only
    for (int i = 0; i < 8; i++) begin
      m  = 7 + rnd() % 57;
      ns = rnd() % 2;
      nf = rnd() % 3;
      x  = fl2(256 * (2 - ns) / (m * (1 << nf)));
      apb(1'b1, `PRS_IDX_LAYOUT, 32'(nf));
      apb(1'b1, `PRS_IDX_MULT, 32'(ns * 128 + m));
      apb(1'b0, `PRS_IDX_STATUS, 0);
      chk("interpolation", 32'(x), {25'h0, q[6:0]});
      chk("length", 32'(x * m), {22'h0, q[25:16]});
    end
    // bypass setup: single tap 1024, seven multiplies, non-symmetric
    apb(1'b1, `PRS_IDX_LAYOUT, 0);
    apb(1'b1, `PRS_IDX_MULT, 32'h87);
    apb(1'b1, `PRS_IDX_COEF_ADDR, 0);
    apb(1'b1, `PRS_IDX_COEF_DATA, 32'h400);
    repeat (255) apb(1'b1, `PRS_IDX_COEF_DATA, 0);
    // prime the delay line; phase zero after reset gives one extra output
    run(8, 9, -1, 0);
    // every rounding width, last one forced to saturate
    for (int k = 0; k < 4; k++) begin
      sh = (k == 3) ? 15 : rnd() % 16;
      apb(1'b1, `PRS_IDX_SHRND, 32'(k * 16 + sh));
      run(4, 4, k, sh);
    end
    // symmetric mode folds upper taps, single tap result unchanged
    apb(1'b1, `PRS_IDX_MULT, 32'h07);
    apb(1'b1, `PRS_IDX_SHRND, 32'h15);
    run(4, 4, 1, 5);
    // four interleaved sets, channel 0 on set 2 of half gain, clock divided by 3
    apb(1'b1, `PRS_IDX_LAYOUT, 32'h02);
    apb(1'b1, `PRS_IDX_FSEL, 32'h02);
    apb(1'b1, `PRS_IDX_DIV, 32'h02);
    apb(1'b1, `PRS_IDX_COEF_ADDR, 32'h02);
    apb(1'b1, `PRS_IDX_COEF_DATA, 32'h200);
    apb(1'b1, `PRS_IDX_SHRND, 32'h26);
    run(4, 4, 2, 5);
    // rate word 1 decimates by two, chosen through the map
    apb(1'b1, `PRS_IDX_RATE0 + 6'h1, 32'h08000000);
    apb(1'b1, `PRS_IDX_MAP, 1);
    run(8, 4, -1, 0);
    apb(1'b1, `PRS_IDX_RSYNC, 1);
    apb(1'b1, `PRS_IDX_MAP, 0);
    run(8, 4, -1, 0);
    @(posedge clk);
    sync_in <= 1'b1;
    repeat (4) @(posedge clk);
    sync_in <= 1'b0;
    run(8, 8, -1, 0);
    // map applied at first output completion: outputs at samples 0,1,3,5,7
    apb(1'b1, `PRS_IDX_RSYNC, 2);
    apb(1'b1, `PRS_IDX_MAP, 1);
    run(8, 5, -1, 0);
    stop_test;
  end

  // cut a hang short
  initial begin
    #500000;
    n_fail++;
    stop_test;
  end
endmodule
`default_nettype wire
